/* File: rtl/acg_regs.vh */
// Register map and field layout of the audio clock generator
`ifndef ACG_REGS_VH
`define ACG_REGS_VH
// Register indices; byte address is four times the index
`define ACG_IDX_SRC 8'h66
`define ACG_IDX_CTRL 8'h80
`define ACG_IDX_QDIV 8'h81
`define ACG_IDX_PLL 8'h82
`define ACG_IDX_ODIV 8'h83
`define ACG_IDX_STAT 8'h84
// Clock source select fields
`define ACG_DIVSRC_HI 7
`define ACG_DIVSRC_LO 6
`define ACG_SYNSRC_HI 5
`define ACG_SYNSRC_LO 4
// Control bits
`define ACG_CTRL_PLLEN 0
`define ACG_CTRL_OSEL 1
`define ACG_CTRL_CONV 2
`define ACG_CTRL_OUTEN 3
// Ratio register fields: J, D, R, P
`define ACG_J_HI 5
`define ACG_J_LO 0
`define ACG_D_HI 19
`define ACG_D_LO 6
`define ACG_R_HI 23
`define ACG_R_LO 20
`define ACG_P_HI 26
`define ACG_P_LO 24
// Output divider fields: M code, N
`define ACG_M_HI 1
`define ACG_M_LO 0
`define ACG_N_HI 6
`define ACG_N_LO 2
// Reset values
`define ACG_RST_SRC 8'h00
`define ACG_RST_CTRL 4'h0
`define ACG_RST_QDIV 5'h02
`define ACG_RST_PLL 27'h110_0001
`define ACG_RST_ODIV 7'h08
// Divide and multiply limits
`define ACG_Q_MIN 5'h02
`define ACG_Q_MAX 5'h11
`define ACG_D_MAX 14'h270f
`define ACG_D_SCALE 17'h02710
// Master clock cycles per reference sample, and pll pre-scale
`define ACG_MCLK_PER_FS 9'h100
`define ACG_PLL_DIV 8'h80
`endif

/* File: rtl/acg_clock_gen.v */
// Audio clock generator: divider, rate synthesiser, output divider
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "acg_regs.vh"

// -----------------------------------------------------------
// Rate accumulator: toggles its clock at inc/mod per edge
// -----------------------------------------------------------
module acg_nco (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire restart,
    input wire src_edge,
    input wire [25:0] inc,
    input wire [25:0] modv,
    // Result
    output reg clk_o,
    output reg tick
);
    reg [27:0] acc;
    // No toggle right after a toggle, so each level lasts at least two cycles
    wire ge = (acc >= {2'b00, modv}) && (modv != 26'h0) && !tick;
    wire room = ~acc[27];
    // Add per source edge, pay at most one toggle every other cycle
    always @(posedge aclk) begin
        if (!aresetn || restart) begin
            acc <= 28'h0;
            clk_o <= 1'b0;
            tick <= 1'b0;
        end else begin
            acc <= acc + ((src_edge && room) ? {2'b00, inc} : 28'h0)
                - (ge ? {2'b00, modv} : 28'h0);
            tick <= ge;
            if (ge)
                clk_o <= ~clk_o;
        end
    end
endmodule

// -----------------------------------------------------------
// Top: register slave and clock paths
// -----------------------------------------------------------
module acg_clock_gen (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write address channel
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // Write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // Write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // Read address channel
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // Read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Clock pins, sampled on aclk
    input wire mclk_in,
    input wire bclk_in,
    input wire aux_pin_two,
    // Generated clocks
    output reg conv_mclk,
    output reg fs_ref_tick,
    output reg aux_pin_one_o,
    output reg aux_pin_one_oe
);
    // -------------------------------------------------------
    // Registers
    // -------------------------------------------------------
    reg [7:0] src_sel;
    reg [3:0] ctrl;
    reg [4:0] qdiv;
    reg [26:0] pll;
    reg [6:0] odiv;
    reg [9:0] aw_idx;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;

    // Merge byte lanes into an old value
    function [31:0] lanes;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer i;
        begin
            lanes = old;
            for (i = 0; i < 4; i = i + 1)
                if (st[i])
                    lanes[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // Clamp to the legal 2..17 divider range
    function [4:0] clampq;
        input [4:0] v;
        begin
            if (v < `ACG_Q_MIN)
                clampq = `ACG_Q_MIN;
            else if (v > `ACG_Q_MAX)
                clampq = `ACG_Q_MAX;
            else
                clampq = v;
        end
    endfunction

    // -------------------------------------------------------
    // Write channel: address and data in either order
    // -------------------------------------------------------
    wire do_wr = aw_held && w_held && !s_axi_bvalid;
    wire [9:0] ar_idx = s_axi_araddr[11:2];
    wire wr_map = (aw_idx == {2'b00, `ACG_IDX_SRC})
        || (aw_idx == {2'b00, `ACG_IDX_CTRL})
        || (aw_idx == {2'b00, `ACG_IDX_QDIV})
        || (aw_idx == {2'b00, `ACG_IDX_PLL})
        || (aw_idx == {2'b00, `ACG_IDX_ODIV});
    // Byte lanes merged into each register's present value
    wire [31:0] m_src = lanes({24'h0, src_sel}, w_data, w_strb);
    wire [31:0] m_ctrl = lanes({28'h0, ctrl}, w_data, w_strb);
    wire [31:0] m_qdiv = lanes({27'h0, qdiv}, w_data, w_strb);
    wire [31:0] m_pll = lanes({5'h0, pll}, w_data, w_strb);
    wire [31:0] m_odiv = lanes({25'h0, odiv}, w_data, w_strb);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 10'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            src_sel <= `ACG_RST_SRC;
            ctrl <= `ACG_RST_CTRL;
            qdiv <= `ACG_RST_QDIV;
            pll <= `ACG_RST_PLL;
            odiv <= `ACG_RST_ODIV;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx <= s_axi_awaddr[11:2];
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                case (aw_idx)
                    {2'b00, `ACG_IDX_SRC}:
                        src_sel <= m_src[7:0] & 8'hf0;
                    {2'b00, `ACG_IDX_CTRL}:
                        ctrl <= m_ctrl[3:0];
                    {2'b00, `ACG_IDX_QDIV}:
                        qdiv <= m_qdiv[4:0];
                    {2'b00, `ACG_IDX_PLL}:
                        pll <= m_pll[26:0];
                    {2'b00, `ACG_IDX_ODIV}:
                        odiv <= m_odiv[6:0];
                    default: ;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------
    // Ratio decode from software fields
    // -------------------------------------------------------
    wire [5:0] j_raw = pll[`ACG_J_HI:`ACG_J_LO];
    wire [13:0] d_raw = pll[`ACG_D_HI:`ACG_D_LO];
    wire [5:0] j_val = (j_raw == 6'h0) ? 6'h01 : j_raw;
    wire [13:0] d_val = (d_raw > `ACG_D_MAX) ? `ACG_D_MAX : d_raw;
    wire [4:0] r_val = {1'b0, pll[`ACG_R_HI:`ACG_R_LO]}
        + {(pll[`ACG_R_HI:`ACG_R_LO] == 4'h0), 4'h0};
    wire [3:0] p_val = {1'b0, pll[`ACG_P_HI:`ACG_P_LO]}
        + {(pll[`ACG_P_HI:`ACG_P_LO] == 3'h0), 3'h0};
    wire [3:0] m_val = 4'h1 << odiv[`ACG_M_HI:`ACG_M_LO];
    wire [4:0] n_val = clampq(odiv[`ACG_N_HI:`ACG_N_LO]);
    wire [4:0] q_val = clampq(qdiv);
    // K in units of 1/10000
    wire [19:0] k_val = j_val * `ACG_D_SCALE + {6'h0, d_val};
    wire [25:0] kr = k_val * r_val;
    wire [25:0] ppre = `ACG_PLL_DIV * `ACG_D_SCALE / 26'd32 * p_val;
    wire [25:0] mnp = m_val * n_val * p_val * `ACG_D_SCALE;
    wire [7:0] mn_val = m_val * n_val;

    // Next increments and moduli for both paths
    wire pll_on = ctrl[`ACG_CTRL_PLLEN];
    wire osel = ctrl[`ACG_CTRL_OSEL];
    wire [25:0] next_ci = pll_on ? kr : 26'h4;
    wire [25:0] next_cm = pll_on ? ppre : {21'h0, q_val};
    wire [25:0] next_oi = osel ? 26'h4 : (pll_on ? {kr[23:0], 2'b00}
        : 26'h0);
    wire [25:0] next_om = osel ? {18'h0, mn_val}
        : mnp;

    // -------------------------------------------------------
    // Active configuration, swapped only while clocks low
    // -------------------------------------------------------
    reg [25:0] ci, cm, oi, om;
    reg [7:0] a_src;
    reg a_pll, a_osel, a_conv;
    wire pend = (next_ci != ci) || (next_cm != cm)
        || (next_oi != oi) || (next_om != om) || (a_src != src_sel)
        || (a_pll != pll_on) || (a_osel != osel)
        || (a_conv != ctrl[`ACG_CTRL_CONV]);
    wire c_lvl, o_lvl, c_tick, o_tick;
    wire apply = pend && !c_lvl && !o_lvl;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ci <= 26'h0;
            cm <= 26'h0;
            oi <= 26'h0;
            om <= 26'h0;
            a_src <= 8'h0;
            a_pll <= 1'b0;
            a_osel <= 1'b0;
            a_conv <= 1'b0;
        end else if (apply) begin
            ci <= next_ci;
            cm <= next_cm;
            oi <= next_oi;
            om <= next_om;
            a_src <= src_sel;
            a_pll <= pll_on;
            a_osel <= osel;
            a_conv <= ctrl[`ACG_CTRL_CONV];
        end
    end

    // -------------------------------------------------------
    // Source pins: edge detection and selection
    // -------------------------------------------------------
    reg [2:0] pin_d;
    wire [2:0] pin_now = {aux_pin_two, bclk_in, mclk_in};
    wire [2:0] rise = pin_now & ~pin_d;
    wire [1:0] dsel = a_src[`ACG_DIVSRC_HI:`ACG_DIVSRC_LO];
    wire [1:0] ssel = a_src[`ACG_SYNSRC_HI:`ACG_SYNSRC_LO];
    // Unused code 11 falls back to the master clock
    wire div_edge = (dsel == 2'b01) ? rise[1]
        : (dsel == 2'b10) ? rise[2] : rise[0];
    // Aux pin two feeds the synthesiser only with converters off
    wire syn_edge = (ssel == 2'b01) ? rise[1]
        : (ssel == 2'b10 && !a_conv) ? rise[2]
        : rise[0];

    always @(posedge aclk) begin
        if (!aresetn)
            pin_d <= 3'h0;
        else
            pin_d <= pin_now;
    end

    // -------------------------------------------------------
    // Converter master clock and output clock accumulators
    // -------------------------------------------------------
    acg_nco u_conv (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(apply),
        .src_edge(a_pll ? syn_edge : div_edge),
        .inc(ci),
        .modv(cm),
        .clk_o(c_lvl),
        .tick(c_tick)
    );

    acg_nco u_out (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(apply),
        .src_edge(a_osel ? div_edge : syn_edge),
        .inc(oi),
        .modv(om),
        .clk_o(o_lvl),
        .tick(o_tick)
    );

    // -------------------------------------------------------
    // Reference rate strobe: one per 256 master clock cycles
    // -------------------------------------------------------
    reg [8:0] fs_cnt;
    always @(posedge aclk) begin
        if (!aresetn || apply) begin
            fs_cnt <= 9'h0;
            fs_ref_tick <= 1'b0;
        end else begin
            fs_ref_tick <= 1'b0;
            if (c_tick && c_lvl) begin
                fs_cnt <= fs_cnt + 9'h1;
                if (fs_cnt == `ACG_MCLK_PER_FS - 9'h1) begin
                    fs_cnt <= 9'h0;
                    fs_ref_tick <= 1'b1;
                end
            end
        end
    end

    // Clock pins follow the accumulator levels, aux gated by OUTEN, which also drives its enable
    always @(posedge aclk) begin
        if (!aresetn) begin
            conv_mclk <= 1'b0;
            aux_pin_one_o <= 1'b0;
            aux_pin_one_oe <= 1'b0;
        end else begin
            conv_mclk <= c_lvl;
            aux_pin_one_o <= o_lvl & ctrl[`ACG_CTRL_OUTEN];
            aux_pin_one_oe <= ctrl[`ACG_CTRL_OUTEN];
        end
    end

    // -------------------------------------------------------
    // Read channel
    // -------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (ar_idx)
                {2'b00, `ACG_IDX_SRC}: s_axi_rdata <= {24'h0, src_sel};
                {2'b00, `ACG_IDX_CTRL}: s_axi_rdata <= {28'h0, ctrl};
                {2'b00, `ACG_IDX_QDIV}: s_axi_rdata <= {27'h0, qdiv};
                {2'b00, `ACG_IDX_PLL}: s_axi_rdata <= {5'h0, pll};
                {2'b00, `ACG_IDX_ODIV}: s_axi_rdata <= {25'h0, odiv};
                {2'b00, `ACG_IDX_STAT}:
                    s_axi_rdata <= {29'h0, o_lvl, c_lvl, pend};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/acg_clock_gen_chk.sv */
// Checker: bus handshake and clock output properties of the clock generator
`timescale 1ns/1ps
`default_nettype none
module acg_clock_gen_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Generated clocks
    input wire logic conv_mclk,
    input wire logic fs_ref_tick,
    input wire logic aux_pin_one_o,
    input wire logic aux_pin_one_oe
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ---------------------------------------------------------------
    // Sequences
    // ---------------------------------------------------------------
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence conv_rise;
        !conv_mclk ##1 conv_mclk;
    endsequence
    sequence aux_fall;
        aux_pin_one_o ##1 !aux_pin_one_o;
    endsequence
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    chk_b_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    chk_wr_refused: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_r_answer: assert property (rd_taken |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0)
        else $error("error read with data");
    chk_tick_pulse: assert property (fs_ref_tick |=> !fs_ref_tick)
        else $error("reference tick too long");
    chk_aux_quiet: assert property (!aux_pin_one_oe |-> !aux_pin_one_o)
        else $error("aux output high while not driven");
    chk_conv_runt: assert property (conv_rise |=> conv_mclk)
        else $error("runt high on converter clock");
    chk_aux_runt: assert property (aux_fall |=> !aux_pin_one_o)
        else $error("runt low on aux output");
endmodule

bind acg_clock_gen acg_clock_gen_chk u_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .conv_mclk(conv_mclk),
    .fs_ref_tick(fs_ref_tick), .aux_pin_one_o(aux_pin_one_o),
    .aux_pin_one_oe(aux_pin_one_oe)
);
`default_nettype wire

/* File: sim/acg_src.sv */
// Partner: free-running clock sources on the three clock pins
`timescale 1ns/1ps
`default_nettype none
module acg_src #(
    parameter int MH = 3,
    parameter int BH = 4,
    parameter int AH = 5
) (
    // Clock
    input wire logic aclk,
    // Clock pins
    output logic mclk_in = 1'b0,
    output logic bclk_in = 1'b0,
    output logic aux_pin_two = 1'b0
);
    int cm = 0;
    int cb = 0;
    int ca = 0;
    // Each pin toggles after its half period and never stops
    always @(posedge aclk) begin
        cm <= (cm == MH - 1) ? 0 : cm + 1;
        cb <= (cb == BH - 1) ? 0 : cb + 1;
        ca <= (ca == AH - 1) ? 0 : ca + 1;
        if (cm == MH - 1) mclk_in <= ~mclk_in;
        if (cb == BH - 1) bclk_in <= ~bclk_in;
        if (ca == AH - 1) aux_pin_two <= ~aux_pin_two;
    end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Testbench: register bus and clock rate checks of the clock generator
`timescale 1ns/1ps
`default_nettype none
`include "acg_regs.vh"
module tb;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic prv;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire mclk, bclk, aux2, conv, tick, aux1, aux1_oe;
    logic [34:0] expq[$];
    logic [34:0] note;
    int failures = 0;
    int compares = 0;
    int n, q, s, t;
    // Clock
    always #4 aclk = ~aclk;
    acg_clock_gen u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mclk_in(mclk), .bclk_in(bclk),
        .aux_pin_two(aux2), .conv_mclk(conv), .fs_ref_tick(tick),
        .aux_pin_one_o(aux1), .aux_pin_one_oe(aux1_oe)
    );
    acg_src u_src (
        .aclk(aclk), .mclk_in(mclk), .bclk_in(bclk), .aux_pin_two(aux2)
    );
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic hang();
        failures++;
        $display("ERROR %0t: wait ran out", $time);
        test_done();
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d,
                      input logic [3:0] st, input logic [1:0] er);
        expq.push_back({1'b0, er, 32'h0});
        @(posedge aclk);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (t = 0; t < 64; t++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            // Take the answer one edge late, so it must stand
            if (bvalid) bready <= 1'b1;
        end
        if (t == 64) hang();
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] d,
                      input logic [1:0] er);
        expq.push_back({1'b1, er, d});
        @(posedge aclk);
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        for (t = 0; t < 64; t++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            // Take the data one edge late, so it must stand
            if (rvalid) rready <= 1'b1;
        end
        if (t == 64) hang();
        rready <= 1'b0;
    endtask
    // Counts rising edges of one clock output after a settling time
    task automatic rate(input bit pin, input int w);
        n = 0;
        repeat (100) @(posedge aclk);
        prv = pin ? aux1 : conv;
        repeat (w) begin
            @(posedge aclk);
            if ((pin ? aux1 : conv) === 1'b1 && prv === 1'b0) n++;
            prv = pin ? aux1 : conv;
        end
    endtask
    function automatic logic [31:0] near(input int x);
        return {31'h0, n >= x - 2 && n <= x + 2};
    endfunction
    // Result watcher: compares each bus answer with the oldest note
    always @(posedge aclk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            note = expq.pop_front();
            check({30'h0, note[34] ? rresp : bresp},
                  {30'h0, note[33:32]});
            if (note[34]) check(rdata, note[31:0]);
        end
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        q = $urandom(20994);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped index, empty strobe, top Q
        rd(`ACG_IDX_SRC, {24'h0, `ACG_RST_SRC}, 2'h0);
        rd(`ACG_IDX_CTRL, {28'h0, `ACG_RST_CTRL}, 2'h0);
        rd(`ACG_IDX_QDIV, {27'h0, `ACG_RST_QDIV}, 2'h0);
        rd(`ACG_IDX_PLL, {5'h0, `ACG_RST_PLL}, 2'h0);
        rd(`ACG_IDX_ODIV, {25'h0, `ACG_RST_ODIV}, 2'h0);
        rd(8'h70, 32'h0, 2'h2);
        wr(8'h70, 32'hffff_ffff, 4'hf, 2'h2);
        wr(`ACG_IDX_ODIV, 32'h7f, 4'h0, 2'h0);
        rd(`ACG_IDX_ODIV, {25'h0, `ACG_RST_ODIV}, 2'h0);
        wr(`ACG_IDX_QDIV, 32'h11, 4'hf, 2'h0);
        rd(`ACG_IDX_QDIV, 32'h11, 2'h0);
        // Divider path from each source, random even Q
        wr(`ACG_IDX_CTRL, 32'h4, 4'hf, 2'h0);
        for (s = 0; s < 3; s++) begin
            q = 2 * $urandom_range(8, 1);
            wr(`ACG_IDX_SRC, s << 6, 4'hf, 2'h0);
            wr(`ACG_IDX_QDIV, q, 4'hf, 2'h0);
            rate(1'b0, 2400);
            check(near(2400 / ((3 + s) * q)), 32'h1);
        end
        // Converter clocks between two reference ticks
        wr(`ACG_IDX_SRC, 32'h0, 4'hf, 2'h0);
        wr(`ACG_IDX_QDIV, 32'h2, 4'hf, 2'h0);
        repeat (100) @(posedge aclk);
        for (t = 0; t < 4000 && tick !== 1'b1; t++) @(posedge aclk);
        if (t == 4000) hang();
        n = 0;
        prv = conv;
        for (t = 0; t < 4000; t++) begin
            @(posedge aclk);
            if (conv === 1'b1 && prv === 1'b0) n++;
            prv = conv;
            if (tick === 1'b1) break;
        end
        check(near(256), 32'h1);
        // Synthesiser with a fractional multiplier, K = 4.5, P = 3
        wr(`ACG_IDX_PLL, 32'h0314_e204, 4'hf, 2'h0);
        rd(`ACG_IDX_PLL, 32'h0314_e204, 2'h0);
        wr(`ACG_IDX_CTRL, 32'h5, 4'hf, 2'h0);
        rate(1'b0, 3200);
        check(near(3200 * 45 / (6 * 10 * 8 * 3)), 32'h1);
        // Synthesiser fed from the bit clock, K = 8
        wr(`ACG_IDX_SRC, 32'h10, 4'hf, 2'h0);
        wr(`ACG_IDX_PLL, 32'h0110_0008, 4'hf, 2'h0);
        rate(1'b0, 1600);
        check(near(1600 * 8 / (8 * 8)), 32'h1);
        // Aux output through the synthesiser, M = 4, N = 4
        wr(`ACG_IDX_SRC, 32'h0, 4'hf, 2'h0);
        wr(`ACG_IDX_ODIV, 32'h12, 4'hf, 2'h0);
        wr(`ACG_IDX_CTRL, 32'hd, 4'hf, 2'h0);
        rate(1'b1, 1200);
        check(near(1200 * 2 * 8 / (6 * 4 * 4)), 32'h1);
        check({31'h0, aux1_oe}, 32'h1);
        // Aux output from the divider source, synthesiser on and off
        for (s = 0; s < 2; s++) begin
            wr(`ACG_IDX_CTRL, s ? 32'he : 32'hf, 4'hf, 2'h0);
            rate(1'b1, 2400);
            check(near(2400 * 2 / (6 * 4 * 4)), 32'h1);
        end
        // Synthesiser off and divider source not chosen: aux quiet
        wr(`ACG_IDX_CTRL, 32'hc, 4'hf, 2'h0);
        rate(1'b1, 600);
        check(n, 32'h0);
        // Converters off: aux pin two routed out through synthesiser
        wr(`ACG_IDX_SRC, 32'h20, 4'hf, 2'h0);
        wr(`ACG_IDX_CTRL, 32'h9, 4'hf, 2'h0);
        rate(1'b1, 1200);
        check(near(1200 * 2 * 8 / (10 * 4 * 4)), 32'h1);
        test_done();
    end
endmodule
`default_nettype wire
